// [design/gain_compressor.sv]
// gain compressor control with adc decimation, high-pass filter and dac modulator
// assumes analog comparators drive asynchronous levels and a host drives the
// register port synchronously to clk_i

`include "gain_compressor_defs.svh"

// ****************************************
// sample fifo
// ****************************************
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem_ff [DEPTH]; // sample storage
    logic [AW-1:0] wr_ptr_ff; // write pointer
    logic [AW-1:0] rd_ptr_ff; // read pointer
    logic [CW-1:0] count_ff; // words held
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = (count_ff != CW'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign out_data_o = mem_ff[rd_ptr_ff];
    assign count_o = count_ff;

    // pointer and count update
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

    // storage write, no reset needed
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end
endmodule

// ****************************************
// gain compressor top
// ****************************************
module gain_compressor
    import gain_compressor_pkg::*;
#(
    parameter int GAIN_W = 7,
    parameter logic [6:0] GAIN_TOP = 7'h52,
    parameter int HOLD_LONG_TICKS = `GC_HOLD_LONG_MS * `GC_SYS_KHZ,
    parameter int HOLD_SHORT_TICKS = `GC_HOLD_SHORT_MS * `GC_SYS_KHZ,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // analog comparators, asynchronous levels
    input wire logic above_upper_i,
    input wire logic above_lower_i,
    // applied gain to the amplifier
    output logic [GAIN_W-1:0] gain_o,
    // adc modulator bit stream at the system rate
    input wire logic adc_bit_i,
    output logic adc_overrun_o,
    // dac sample input and modulator output
    input wire logic [15:0] dac_sample_i,
    input wire logic dac_valid_i,
    output logic dac_ready_o,
    output logic [3:0] dac_mod_o
);
    // ****************************************
    // timing enables
    // ****************************************
    localparam int FIXED_DIV = (`GC_SYS_KHZ * `GC_STEP_MDB) / (`GC_FIXED_KDBPS * 1000);
    localparam int HW = $clog2(HOLD_LONG_TICKS + 1);

    // rate prescaler mask: a tick every 2^sel system ticks
    function automatic logic [15:0] rate_mask(input logic [3:0] sel);
        rate_mask = (16'h0001 << sel) - 16'h0001;
    endfunction

    logic [16:0] phase_ff; // fractional divider for the system rate
    logic sys_tick_ff; // one-cycle 1.28 MHz enable
    logic [15:0] pre_ff; // free-running system tick counter
    logic [3:0] fix_cnt_ff; // fixed-mode step divider
    wire [16:0] phase_sum = phase_ff + 17'(`GC_SYS_KHZ);
    wire phase_wrap = (phase_sum >= 17'(`GC_CLK_KHZ));

    // system rate enable from the 100 MHz clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_ff <= '0;
            sys_tick_ff <= 1'b0;
            pre_ff <= '0;
            fix_cnt_ff <= '0;
        end else begin
            phase_ff <= phase_wrap ? phase_sum - 17'(`GC_CLK_KHZ) : phase_sum;
            sys_tick_ff <= phase_wrap;
            if (sys_tick_ff) begin
                pre_ff <= pre_ff + 16'h0001;
                fix_cnt_ff <= (fix_cnt_ff == 4'(FIXED_DIV - 1)) ? 4'h0 : fix_cnt_ff + 4'h1;
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] ctrl_ff; // compressor_control_reg
    logic [7:0] gain_set_ff; // gain_setting_reg
    logic [7:0] fast_rate_ff; // fast_rate_reg: [3:0] attack, [7:4] release
    logic [7:0] slow_rate_ff; // slow_rate_format_reg: same layout
    logic [7:0] filt_ff; // filter_format_reg: [1:0] filter select
    logic [15:0] rdata_ff; // read data, one cycle after the strobe
    logic overrun_ff; // sticky sample loss flag
    wire [15:0] fifo_data;
    wire fifo_valid;
    wire [$clog2(FIFO_DEPTH+1)-1:0] fifo_count;
    logic [GAIN_W-1:0] gain_ff; // applied gain

    wire gain_mode_t mode = gain_mode_t'(ctrl_ff[`GC_MODE_HI:`GC_MODE_LO]);
    wire hpf_sel_t hpf = hpf_sel_t'(filt_ff[1:0]);
    wire [6:0] set_gain = (gain_set_ff[6:0] > GAIN_TOP) ? GAIN_TOP : gain_set_ff[6:0];
    wire wr_ctrl = wr_i && (addr_i == `GC_REG_CTRL);
    wire wr_gain = wr_i && (addr_i == `GC_REG_GAIN);
    wire wr_fast = wr_i && (addr_i == `GC_REG_FAST);
    wire wr_slow = wr_i && (addr_i == `GC_REG_SLOW);
    wire wr_filt = wr_i && (addr_i == `GC_REG_FILT);
    wire rd_adc = rd_i && (addr_i == `GC_REG_ADC);
    wire rd_stat = rd_i && (addr_i == `GC_REG_STAT);
    wire [7:0] gain_rd = gain_set_ff[`GC_RDMODE_BIT]
        ? {gain_set_ff[7], 7'(gain_ff)} : gain_set_ff;
    wire [15:0] stat_word = {7'h00, overrun_ff, 8'(fifo_count)};
    wire [15:0] rd_mux = (addr_i == `GC_REG_CTRL) ? {8'h00, ctrl_ff} :
                         (addr_i == `GC_REG_GAIN) ? {8'h00, gain_rd} :
                         (addr_i == `GC_REG_FAST) ? {8'h00, fast_rate_ff} :
                         (addr_i == `GC_REG_SLOW) ? {8'h00, slow_rate_ff} :
                         (addr_i == `GC_REG_FILT) ? {8'h00, filt_ff} :
                         (addr_i == `GC_REG_ADC) ? (fifo_valid ? fifo_data : 16'h0000) :
                         (addr_i == `GC_REG_STAT) ? stat_word : 16'h0000;

    // register writes and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `GC_CTRL_RST;
            gain_set_ff <= `GC_GAIN_RST;
            fast_rate_ff <= `GC_FAST_RST;
            slow_rate_ff <= `GC_SLOW_RST;
            filt_ff <= `GC_FILT_RST;
            rdata_ff <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= {3'h0, wdata_i[4:0]};
            end
            if (wr_gain) begin
                gain_set_ff <= wdata_i;
            end
            if (wr_fast) begin
                fast_rate_ff <= wdata_i;
            end
            if (wr_slow) begin
                slow_rate_ff <= wdata_i;
            end
            if (wr_filt) begin
                filt_ff <= {6'h00, wdata_i[1:0]};
            end
            rdata_ff <= rd_i ? rd_mux : 16'h0000;
        end
    end

    assign rdata_o = rdata_ff;

    // ****************************************
    // comparator synchronisers
    // ****************************************
    logic [2:0] up_sync_ff; // upper threshold, three stages
    logic [2:0] lo_sync_ff; // lower threshold, three stages
    logic up_ff; // accepted upper level
    logic lo_ff; // accepted lower level

    // a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up_sync_ff <= 3'h0;
            lo_sync_ff <= 3'h0;
            up_ff <= 1'b0;
            lo_ff <= 1'b0;
        end else begin
            up_sync_ff <= {up_sync_ff[1:0], above_upper_i};
            lo_sync_ff <= {lo_sync_ff[1:0], above_lower_i};
            if (up_sync_ff[1] == up_sync_ff[2]) begin
                up_ff <= up_sync_ff[2];
            end
            if (lo_sync_ff[1] == lo_sync_ff[2]) begin
                lo_ff <= lo_sync_ff[2];
            end
        end
    end

    // ****************************************
    // gain counters
    // ****************************************
    logic [GAIN_W-1:0] fast_ff; // fast-rate counter
    logic [GAIN_W-1:0] slow_ff; // slow-rate counter
    logic [HW-1:0] hold_ff; // time spent below the lower threshold
    wire [HW-1:0] hold_lim = ctrl_ff[`GC_HOLD_BIT]
        ? HW'(HOLD_SHORT_TICKS) : HW'(HOLD_LONG_TICKS);
    wire hold_done = (hold_ff >= hold_lim);
    wire [15:0] fa_m = rate_mask(fast_rate_ff[3:0]);
    wire [15:0] fr_m = rate_mask(fast_rate_ff[7:4]);
    wire [15:0] sa_m = rate_mask(slow_rate_ff[3:0]);
    wire [15:0] sr_m = rate_mask(slow_rate_ff[7:4]);
    wire fa_tick = sys_tick_ff && ((pre_ff & fa_m) == fa_m);
    wire fr_tick = sys_tick_ff && ((pre_ff & fr_m) == fr_m);
    wire sa_tick = sys_tick_ff && ((pre_ff & sa_m) == sa_m);
    wire sr_tick = sys_tick_ff && ((pre_ff & sr_m) == sr_m);
    wire fix_tick = sys_tick_ff && (fix_cnt_ff == 4'h0);
    wire [GAIN_W-1:0] max_g = GAIN_W'(set_gain);
    wire auto_mode = (mode == MODE_AUTO_DUAL) || (mode == MODE_AUTO_SINGLE);
    logic [GAIN_W-1:0] nxt_fast;
    logic [GAIN_W-1:0] nxt_slow;
    logic [GAIN_W-1:0] nxt_gain;

    // next counter and gain values
    always_comb begin
        nxt_fast = fast_ff;
        nxt_slow = slow_ff;
        nxt_gain = gain_ff;
        if (auto_mode) begin
            if (fast_ff > max_g) begin
                nxt_fast = max_g;
            end else if (up_ff && fa_tick && fast_ff != '0) begin
                nxt_fast = fast_ff - 1'b1;
            end else if (!lo_ff && hold_done && fr_tick && fast_ff < max_g) begin
                nxt_fast = fast_ff + 1'b1;
            end
            if (mode == MODE_AUTO_DUAL) begin
                if (slow_ff > fast_ff && sa_tick) begin
                    nxt_slow = slow_ff - 1'b1;
                end else if (slow_ff < fast_ff && sr_tick) begin
                    nxt_slow = slow_ff + 1'b1;
                end
                nxt_gain = (nxt_slow < nxt_fast) ? nxt_slow : nxt_fast;
            end else begin
                nxt_slow = nxt_fast;
                nxt_gain = nxt_fast;
            end
        end else begin
            if (mode == MODE_FIXED_IMM) begin
                nxt_gain = max_g;
            end else if (fix_tick && gain_ff > max_g) begin
                nxt_gain = gain_ff - 1'b1;
            end else if (fix_tick && gain_ff < max_g) begin
                nxt_gain = gain_ff + 1'b1;
            end
            nxt_fast = nxt_gain;
            nxt_slow = nxt_gain;
        end
    end

    // counter registers and hold timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_ff <= '0;
            slow_ff <= '0;
            gain_ff <= '0;
            hold_ff <= '0;
        end else begin
            fast_ff <= nxt_fast;
            slow_ff <= nxt_slow;
            gain_ff <= nxt_gain;
            if (lo_ff) begin
                hold_ff <= '0;
            end else if (sys_tick_ff && !hold_done) begin
                hold_ff <= hold_ff + 1'b1;
            end
        end
    end

    assign gain_o = gain_ff;

    // ****************************************
    // adc decimation and high-pass filter
    // ****************************************
    logic [5:0] dec_cnt_ff; // position within 64 modulator bits
    logic [6:0] ones_ff; // ones counted in the current block
    logic signed [15:0] x_prev_ff; // previous filter input
    logic signed [23:0] y_ff; // filter state with 8 fraction bits
    logic [15:0] pend_ff; // sample waiting for fifo room
    logic pend_valid_ff; // pending sample present
    wire fifo_in_ready;
    wire [6:0] ones_nxt = ones_ff + {6'h00, adc_bit_i};
    // map 0..64 ones onto the two's complement range, clamped at the top
    wire signed [15:0] x_new = (ones_nxt == 7'd64) ? 16'sh7FFF
        : 16'(({9'h000, ones_nxt} << 10) - 17'h08000);
    wire signed [23:0] y_shr = (hpf == HPF_100HZ) ? (y_ff >>> `GC_HPF100_SHIFT)
        : (y_ff >>> `GC_HPF50_SHIFT);
    wire signed [23:0] y_new = y_ff - y_shr + 24'({x_new - x_prev_ff, 8'h00});
    wire signed [23:0] y_sat = (y_new > 24'sh7FFF00) ? 24'sh7FFF00 :
                               (y_new < -24'sh800000) ? -24'sh800000 : y_new;
    wire hpf_on = (hpf == HPF_50HZ) || (hpf == HPF_100HZ);
    wire [15:0] out_word = hpf_on ? y_sat[23:8] : x_new;
    wire dec_done = sys_tick_ff && (dec_cnt_ff == 6'(`GC_ADC_OSR - 1));

    // one output word per 64 system ticks, 20 kHz
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_cnt_ff <= '0;
            ones_ff <= '0;
            x_prev_ff <= '0;
            y_ff <= '0;
            pend_ff <= 16'h0000;
            pend_valid_ff <= 1'b0;
            overrun_ff <= 1'b0;
        end else begin
            if (sys_tick_ff) begin
                dec_cnt_ff <= dec_cnt_ff + 6'h01;
                ones_ff <= dec_done ? 7'h00 : ones_nxt;
            end
            if (dec_done) begin
                x_prev_ff <= x_new;
                y_ff <= y_sat;
                pend_ff <= out_word;
            end
            // a full fifo stalls the pending word; a new word then replaces it
            if (dec_done) begin
                pend_valid_ff <= 1'b1;
            end else if (fifo_in_ready) begin
                pend_valid_ff <= 1'b0;
            end
            if (dec_done && pend_valid_ff && !fifo_in_ready) begin
                overrun_ff <= 1'b1;
            end else if (rd_stat) begin
                overrun_ff <= 1'b0;
            end
        end
    end

    assign adc_overrun_o = overrun_ff;

    sample_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(pend_valid_ff),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pend_ff),
        .out_valid_o(fifo_valid),
        .out_ready_i(rd_adc),
        .out_data_o(fifo_data),
        .count_o(fifo_count)
    );

    // ****************************************
    // dac modulator
    // ****************************************
    logic dac_div_ff; // halves the system rate to 640 kHz
    logic [4:0] dac_os_ff; // modulator ticks per input sample
    logic signed [15:0] dac_in_ff; // held input sample
    logic signed [16:0] err_ff; // quantisation error
    logic [3:0] mod_ff; // four-bit modulator output
    wire dac_tick = sys_tick_ff && dac_div_ff;
    wire dac_take = dac_tick && (dac_os_ff == 5'(`GC_DAC_OSR - 1));
    wire signed [16:0] dac_sum = err_ff + 17'(dac_in_ff);
    wire [3:0] dac_q = dac_sum[15:12];
    wire signed [16:0] dac_fb = 17'(signed'({dac_q, 12'h000}));

    assign dac_ready_o = dac_take;

    // first-order error feedback, 32 modulator ticks per sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_div_ff <= 1'b0;
            dac_os_ff <= '0;
            dac_in_ff <= '0;
            err_ff <= '0;
            mod_ff <= 4'h0;
        end else begin
            if (sys_tick_ff) begin
                dac_div_ff <= ~dac_div_ff;
            end
            if (dac_tick) begin
                dac_os_ff <= dac_os_ff + 5'h01;
                err_ff <= dac_sum - dac_fb;
                mod_ff <= dac_q;
            end
            if (dac_take && dac_valid_i) begin
                dac_in_ff <= dac_sample_i;
            end
        end
    end

    assign dac_mod_o = mod_ff;
endmodule

// [design/gain_compressor_defs.svh]
// gain compressor constants: register offsets, fields, reset values, timing
// assumes a 100 MHz core clock and a 1.28 MHz system rate made from it by enables
`ifndef GAIN_COMPRESSOR_DEFS_SVH
`define GAIN_COMPRESSOR_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define GC_REG_CTRL 3'h0
`define GC_REG_GAIN 3'h1
`define GC_REG_FAST 3'h2
`define GC_REG_SLOW 3'h3
`define GC_REG_FILT 3'h4
`define GC_REG_ADC 3'h5
`define GC_REG_STAT 3'h6

// ****************************************
// field positions and reset values
// ****************************************
`define GC_MODE_HI 3
`define GC_MODE_LO 2
`define GC_HOLD_BIT 4
`define GC_RDMODE_BIT 7
`define GC_CTRL_RST 8'h00
`define GC_GAIN_RST 8'h52
`define GC_FAST_RST 8'h31
`define GC_SLOW_RST 8'h97
`define GC_FILT_RST 8'h00

// ****************************************
// timing
// ****************************************
`define GC_CLK_KHZ 100000
`define GC_SYS_KHZ 1280
`define GC_HOLD_LONG_MS 50
`define GC_HOLD_SHORT_MS 25
`define GC_FIXED_KDBPS 80
`define GC_STEP_MDB 500
`define GC_ADC_OSR 64
`define GC_DAC_DIV 2
`define GC_DAC_OSR 32
`define GC_HPF50_SHIFT 7
`define GC_HPF100_SHIFT 6

`endif

// [design/gain_compressor_pkg.sv]
// gain compressor types: gain modes and filter selections
// assumes the constants header sits beside it

package gain_compressor_pkg;
    // gain control mode, encoded as the two-bit control field
    typedef enum logic [1:0] {
        MODE_AUTO_DUAL = 2'h0,
        MODE_AUTO_SINGLE = 2'h1,
        MODE_FIXED_STEP = 2'h2,
        MODE_FIXED_IMM = 2'h3
    } gain_mode_t;
    // high-pass filter selection
    typedef enum logic [1:0] {
        HPF_50HZ = 2'h0,
        HPF_100HZ = 2'h1,
        HPF_BYPASS = 2'h2,
        HPF_BYPASS_ALT = 2'h3
    } hpf_sel_t;
endpackage

// [dv/gain_compressor_asserts.sv]
// checker: port relations of the gain compressor
// assumes it is bound into gain_compressor and sees its ports only
module gain_compressor_chk #(
    parameter logic [6:0] GAIN_TOP = 7'h52,
    parameter int HOLD_SHORT_TICKS = 32000
) (
    // clock, reset, register port
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    // comparator, gain and dac handshake
    input wire logic above_lower_i,
    input wire logic [6:0] gain_o,
    input wire logic dac_ready_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] mode_ff; // shadow of the mode field
    logic [7:0] set_ff; // shadow of the gain setting
    logic [6:0] gain_ff; // gain one cycle back
    int low_ff; // cycles with the lower comparator low
    int fx_ff; // cycles since the last step in fixed-step mode
    int dac_ff; // cycles since the last dac sample request
    wire logic [6:0] tgt = (set_ff[6:0] > GAIN_TOP) ? GAIN_TOP : set_ff[6:0];
    // shadow registers and counters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= 2'h0;
            set_ff <= 8'h52;
            low_ff <= 0;
            fx_ff <= 1023;
            dac_ff <= 9999;
        end else begin
            if (wr_i && addr_i == 3'h0) mode_ff <= wdata_i[3:2];
            if (wr_i && addr_i == 3'h1) set_ff <= wdata_i;
            low_ff <= above_lower_i ? 0 : low_ff + 1;
            fx_ff <= (mode_ff != 2'h2) ? 1023 : (gain_o != gain_ff) ? 0 : fx_ff + 1;
            dac_ff <= dac_ready_o ? 0 : (dac_ff < 9999) ? dac_ff + 1 : dac_ff;
        end
        gain_ff <= gain_o;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0)
        else $error("read data not idle");
    a_gain_read: assert property (rd_i && addr_i == 3'h1 |=>
        rdata_o == {8'h0, set_ff[7] ? {1'b1, $past(gain_o)} : set_ff})
        else $error("gain readback wrong");
    a_gain_step: assert property (mode_ff != 2'h3 && $stable(mode_ff) &&
        $past(mode_ff) == $past(mode_ff, 2) |->
        gain_o == gain_ff || gain_o == gain_ff + 7'h1 || gain_o + 7'h1 == gain_ff)
        else $error("gain jumped");
    a_gain_cap: assert property (gain_o <= GAIN_TOP)
        else $error("gain above maximum");
    a_imm_apply: assert property (mode_ff == 2'h3 && wr_i && addr_i == 3'h1 |->
        ##[1:3] gain_o == tgt)
        else $error("immediate gain late");
    a_fixed_move: assert property (mode_ff == 2'h2 && gain_o != tgt |->
        ##[1:700] gain_o != gain_ff)
        else $error("fixed gain stuck");
    a_fixed_rate: assert property (mode_ff == 2'h2 && gain_o != gain_ff |-> fx_ff >= 600)
        else $error("fixed step too fast");
    a_hold_time: assert property (mode_ff == 2'h1 && $past(mode_ff) == 2'h1 &&
        gain_o > gain_ff |-> low_ff >= HOLD_SHORT_TICKS * 78)
        else $error("gain rose before hold");
    a_dac_space: assert property (dac_ready_o |-> dac_ff >= 4990 ##1 !dac_ready_o)
        else $error("dac request spacing");
    c_imm: cover property (mode_ff == 2'h3 && wr_i && addr_i == 3'h1);
    c_live: cover property (rd_i && addr_i == 3'h1 && set_ff[7]);
    c_dac: cover property (dac_ready_o);
endmodule

bind gain_compressor gain_compressor_chk #(
    .GAIN_TOP(GAIN_TOP),
    .HOLD_SHORT_TICKS(HOLD_SHORT_TICKS)
) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .above_lower_i(above_lower_i), .gain_o(gain_o),
    .dac_ready_o(dac_ready_o)
);

// [dv/peak_comparator_model.sv]
// partner: amplifier output against the two peak comparators
// assumes levels in 0.5 dB codes; output code is input level plus gain
module peak_comparator_model #(
    parameter logic [7:0] UPPER_CODE = 8'h50
) (
    input wire logic [7:0] level_i,
    input wire logic [6:0] gain_i,
    output logic above_upper_o,
    output logic above_lower_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] out_code; // amplifier output, late like an analog path
    assign #3 out_code = level_i + {1'b0, gain_i};
    assign above_upper_o = out_code > UPPER_CODE;
    assign above_lower_o = out_code > UPPER_CODE - 8'h06;
endmodule

// [dv/test_gain_compressor.sv]
// testbench: gain modes, readback, adc words and dac pacing
// assumes one 100 MHz clock and the comparator model as far side
`define CHECK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module test_gain_compressor import gain_compressor_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STEP_CLK = 8 * 100000 / 1280; // clocks per fixed step
    logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00, level = 8'h00;
    logic [15:0] rdata_o, rd_val, dac_sample_i = 16'h0000;
    logic above_upper_i, above_lower_i, adc_overrun_o, dac_ready_o;
    logic adc_bit_i = 1'b0, adc_force = 1'b0, dac_valid_i = 1'b1;
    logic [6:0] gain_o;
    logic [3:0] dac_mod_o;
    logic [31:0] lfsr = 32'h47659CA0;
    int num_errors = 0, tests_run = 0, t_last = 0, cyc = 0, n = 0;
    gain_compressor #(.HOLD_LONG_TICKS(40), .HOLD_SHORT_TICKS(20)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .above_upper_i(above_upper_i),
        .above_lower_i(above_lower_i), .gain_o(gain_o), .adc_bit_i(adc_bit_i),
        .adc_overrun_o(adc_overrun_o), .dac_sample_i(dac_sample_i),
        .dac_valid_i(dac_valid_i), .dac_ready_o(dac_ready_o), .dac_mod_o(dac_mod_o));
    peak_comparator_model i_cmp (.level_i(level), .gain_i(gain_o),
        .above_upper_o(above_upper_i), .above_lower_o(above_lower_i));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // adc word expected for a count of ones in one 64-bit block
    function automatic logic [15:0] adc_word(input int ones);
        return (ones == 64) ? 16'h7FFF : 16'(ones * 1024 - 32768);
    endfunction
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // random adc bits and dac samples, dac pacing measured
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        lfsr <= next_rand(lfsr);
        adc_bit_i <= adc_force | lfsr[7];
        if (dac_ready_o) begin
            dac_sample_i <= lfsr[23:8];
            if (t_last > 0) `CHECK("dac spacing", 1'b1, (cyc - t_last) inside {[4990:5010]})
            t_last <= cyc;
        end
    end
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        d = rdata_o;
    endtask
    task automatic rd_chk(input string s, input logic [2:0] a, input logic [15:0] e);
        logic [15:0] d;
        reg_rd(a, d);
        `CHECK(s, e, d)
    endtask
    task automatic wait_gain(input logic [6:0] g, input int lim);
        int k;
        k = 0;
        while (gain_o !== g && k < lim) begin
            @(posedge clk_i);
            k++;
        end
        `CHECK("gain", g, gain_o)
    endtask
    task automatic wait_step();
        logic [6:0] g;
        g = gain_o;
        n = 0;
        while (gain_o === g && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog far beyond the expected run
    initial begin
        #1000000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk("ctrl", 3'h0, 16'h0000);
        rd_chk("gain reg", 3'h1, 16'h0052);
        rd_chk("fast", 3'h2, 16'h0031);
        rd_chk("slow", 3'h3, 16'h0097);
        `CHECK("dac idle", 4'h0, dac_mod_o)
        reg_wr(3'h7, 8'hFF);
        rd_chk("unmapped", 3'h7, 16'h0000);
        reg_wr(3'h4, 8'hFF);
        rd_chk("filter", 3'h4, 16'h0003);
        reg_wr(3'h1, 8'h40);
        reg_wr(3'h2, 8'h00);
        reg_wr(3'h3, 8'hF0);
        reg_wr(3'h0, {3'h0, 1'b1, MODE_AUTO_SINGLE, 2'h0});
        wait_gain(7'h40, 12000);
        level <= 8'h30;
        wait_gain(7'h20, 6000);
        level <= 8'h00;
        repeat (1000) @(posedge clk_i);
        `CHECK("gain held", 7'h20, gain_o)
        wait_gain(7'h40, 8000);
        reg_wr(3'h0, {3'h0, 1'b1, MODE_FIXED_IMM, 2'h0});
        reg_wr(3'h0, {3'h0, 1'b1, MODE_AUTO_DUAL, 2'h0});
        level <= 8'h30;
        wait_gain(7'h20, 6000);
        level <= 8'h00;
        repeat (7000) @(posedge clk_i);
        `CHECK("dual min", 7'h20, gain_o)
        reg_wr(3'h0, {3'h0, 1'b1, MODE_AUTO_SINGLE, 2'h0});
        wait_gain(7'h40, 3000);
        reg_wr(3'h0, {3'h0, 1'b1, MODE_FIXED_IMM, 2'h0});
        reg_wr(3'h1, 8'h7F);
        wait_gain(7'h52, 4);
        reg_wr(3'h1, 8'h30);
        wait_gain(7'h30, 4);
        reg_wr(3'h0, {3'h0, 1'b1, MODE_FIXED_STEP, 2'h0});
        reg_wr(3'h1, 8'h32);
        rd_chk("stored gain", 3'h1, 16'h0032);
        wait_step();
        `CHECK("step up", 7'h31, gain_o)
        reg_wr(3'h1, 8'hB2);
        rd_chk("live gain", 3'h1, 16'h00B1);
        wait_step();
        `CHECK("step time", 1'b1, (n + 4) inside {[STEP_CLK - 4:STEP_CLK + 4]})
        adc_force <= 1'b1;
        reg_wr(3'h4, {6'h00, HPF_BYPASS});
        reg_rd(3'h6, rd_val);
        repeat (rd_val[7:0]) reg_rd(3'h5, rd_val);
        repeat (2 * 64 * 100000 / 1280 + 2500) @(posedge clk_i);
        reg_rd(3'h6, rd_val);
        `CHECK("words", 1'b1, rd_val[7:0] inside {8'h02, 8'h03})
        repeat (rd_val[7:0]) reg_rd(3'h5, rd_val);
        `CHECK("full scale", adc_word(64), rd_val)
        rd_chk("status", 3'h6, 16'h0000);
        rd_chk("empty word", 3'h5, 16'h0000);
        `CHECK("overrun pin", 1'b0, adc_overrun_o)
        complete_run();
    end
endmodule
